// ### hdl/hbp_half_bridge.sv
`timescale 1ns/1ns
// Summary of operation
// R1 - Half-bridge drives PWM on primary pin, its complement on secondary pin
// R2 - Dead-band delay comes from seven-bit field in low control bits
// R3 - Dead-band longer than active time keeps that output inactive all period
// R4 - Only inactive-to-active edges are delayed; falling edges pass at once
// R5 - Dead-band counts instruction cycles of four oscillator periods each
// R6 - Software clears both direction bits so pins act as outputs
// R7 - Software never enables comparator two pin with secondary PWM output
// R8 - Zero dead-band lets both outputs switch in the same cycle
module hbp_half_bridge
#(
    parameter int unsigned DB_W = hbp_pkg::HBP_DB_W
) (
    input wire logic core_clk, // Oscillator clock
    input wire logic rst, // Asynchronous reset
    input wire logic pwm_in, // Waveform from the PWM core
    input wire logic [hbp_pkg::HBP_ADDR_W-1:0] avs_address, // Byte address
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [3:0] avs_byteenable, // Byte lanes
    input wire logic [31:0] avs_writedata, // Write data
    output logic [31:0] avs_readdata, // Read data
    output logic avs_waitrequest, // Stall
    output logic primary_pwm_out, // Primary pin level
    output logic primary_pwm_oe, // Primary pin drive enable
    output logic complement_pwm_out, // Secondary pin level
    output logic complement_pwm_oe // Secondary pin drive enable
);
    import hbp_pkg::*;

    // ****************************************
    // Derived widths
    // ****************************************
    localparam int unsigned CNT_W = DB_W + 2;
    localparam int unsigned RUN_W = CNT_W + 1;

    // Refuse field widths beyond the control register
    if (DB_W < 1 || DB_W > 7) begin : g_db_w_check
        $error("DB_W must lie between 1 and 7");
    end

    // ****************************************
    // Register bus state
    // ****************************************
    logic [6:0] pwm_control_register;
    logic [6:0] next_pwm_control_register;
    logic [HBP_CFG_W-1:0] cfg;
    logic [HBP_CFG_W-1:0] next_cfg;
    logic waitreq;
    logic next_waitreq;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic req;
    logic take;

    // ****************************************
    // Channel state, index 0 primary, 1 secondary
    // ****************************************
    logic [1:0] out;
    logic [1:0] next_out;
    logic [1:0] pend;
    logic [1:0] next_pend;
    logic [CNT_W-1:0] cnt [2];
    logic [CNT_W-1:0] next_cnt [2];
    logic [1:0] oe;
    logic [1:0] next_oe;
    logic [1:0] tgt;
    logic hb_en;
    logic [DB_W-1:0] deadband_count_field;
    logic [CNT_W-1:0] db_osc;

    // ****************************************
    // Functions
    // ****************************************
    // Read data for one register offset, zero when unmapped
    function automatic logic [31:0] rd_word(input logic [3:0] a);
        logic [31:0] w;
        w = 32'h0000_0000;
        unique case (a)
            HBP_OFS_PWM_CTL: w[6:0] = pwm_control_register;
            HBP_OFS_CFG: w[HBP_CFG_W-1:0] = cfg;
            HBP_OFS_STATUS: begin
                w[HBP_STS_PRI] = out[0];
                w[HBP_STS_CMP] = out[1];
                w[HBP_STS_CONFLICT] = cfg[HBP_CFG_C2_EN] & cfg[HBP_CFG_HB_EN];
                w[HBP_STS_PEND_PRI] = pend[0];
                w[HBP_STS_PEND_CMP] = pend[1];
            end
            default: w = 32'h0000_0000;
        endcase
        return w;
    endfunction : rd_word

    // ****************************************
    // Avalon-MM slave, one wait state per access
    // ****************************************
    assign req = avs_read | avs_write;
    assign take = req & ~waitreq;

    // Next bus state and register writes
    always_comb begin
        next_pwm_control_register = pwm_control_register;
        next_cfg = cfg;
        next_waitreq = ~(req & waitreq);
        next_rdata = rdata;
        if (avs_read && waitreq) begin
            next_rdata = rd_word(avs_address);
        end
        if (avs_write && take && avs_byteenable[0]) begin
            unique case (avs_address)
                HBP_OFS_PWM_CTL: next_pwm_control_register = avs_writedata[6:0];
                HBP_OFS_CFG: next_cfg = avs_writedata[HBP_CFG_W-1:0];
                default: next_cfg = cfg;
            endcase
        end
    end

    // Bus registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pwm_control_register <= HBP_PWM_CTL_RST;
            cfg <= HBP_CFG_RST;
            waitreq <= 1'b1;
            rdata <= HBP_RDATA_RST;
        end else begin
            pwm_control_register <= next_pwm_control_register;
            cfg <= next_cfg;
            waitreq <= next_waitreq;
            rdata <= next_rdata;
        end
    end

    // ****************************************
    // Dead-band generator
    // ****************************************
    // Delay field in low bits, scaled to oscillator periods
    assign deadband_count_field = pwm_control_register[DB_W-1:0]; // R2
    assign db_osc = {deadband_count_field, 2'b00}; // R5
    assign hb_en = cfg[HBP_CFG_HB_EN];
    // Wanted levels: waveform and its complement in half-bridge
    assign tgt[0] = pwm_in; // R1
    assign tgt[1] = hb_en & ~pwm_in; // R1

    // Per-channel edge delay
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            next_out[i] = out[i];
            next_pend[i] = pend[i];
            next_cnt[i] = cnt[i];
            if (!tgt[i]) begin
                // Falling edge passes at once
                next_out[i] = 1'b0; // R4
                next_pend[i] = 1'b0; // R3
                next_cnt[i] = '0;
            end else if (!out[i] && !pend[i]) begin
                if (db_osc == '0) begin
                    next_out[i] = 1'b1; // R8
                end else begin
                    next_pend[i] = 1'b1; // R4
                    next_cnt[i] = db_osc - CNT_W'(1);
                end
            end else if (pend[i]) begin
                if (cnt[i] == '0) begin
                    next_out[i] = 1'b1; // R2
                    next_pend[i] = 1'b0;
                end else begin
                    next_cnt[i] = cnt[i] - CNT_W'(1); // R5
                end
            end
        end
        // Drive enables follow cleared direction bits, secondary only in half-bridge
        next_oe[0] = ~cfg[HBP_CFG_DIR_PRI];
        next_oe[1] = ~cfg[HBP_CFG_DIR_CMP] & hb_en;
    end

    // Channel registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            out <= 2'h0;
            pend <= 2'h0;
            oe <= 2'h0;
            cnt[0] <= '0;
            cnt[1] <= '0;
        end else begin
            out <= next_out;
            pend <= next_pend;
            oe <= next_oe;
            cnt[0] <= next_cnt[0];
            cnt[1] <= next_cnt[1];
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign avs_readdata = rdata;
    assign avs_waitrequest = waitreq;
    assign primary_pwm_out = out[0];
    assign complement_pwm_out = out[1];
    assign primary_pwm_oe = oe[0];
    assign complement_pwm_oe = oe[1];

    // ****************************************
    // Checking helpers
    // ****************************************
    // Cycles each wanted level has been active, saturating
    logic [RUN_W-1:0] run [2];
    logic [RUN_W-1:0] next_run [2];
    logic [RUN_W-1:0] db_run;

    assign db_run = RUN_W'(db_osc);

    // Run length counters
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            next_run[i] = '0;
            if (tgt[i]) begin
                next_run[i] = (&run[i]) ? run[i] : run[i] + RUN_W'(1);
            end
        end
    end

    // Run length registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            run[0] <= '0;
            run[1] <= '0;
        end else begin
            run[0] <= next_run[0];
            run[1] <= next_run[1];
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    // Outputs never both active in half-bridge
    a_no_overlap: assert property ( // R1
        @(posedge core_clk) disable iff (rst)
        !(out[0] && out[1]))
        else $error("both half-bridge outputs active");

    // Primary rises exactly the dead-band plus one cycle after the waveform
    a_pri_delay: assert property ( // R2
        @(posedge core_clk) disable iff (rst)
        $rose(out[0]) |-> run[0] == db_run + RUN_W'(1))
        else $error("primary rise not at dead-band");

    // Secondary rises exactly the dead-band plus one cycle after its level
    a_cmp_delay: assert property ( // R5
        @(posedge core_clk) disable iff (rst)
        $rose(out[1]) |-> run[1] == db_run + RUN_W'(1))
        else $error("secondary rise not at dead-band");

    // Primary stays inactive until its wanted level outlasts the dead band
    // Watched only while inactive, so a new delay under a standing output is legal
    a_short_duty: assert property ( // R3
        @(posedge core_clk) disable iff (rst)
        (!out[0] && run[0] < db_run) |=> !out[0])
        else $error("primary active within short duty");

    // Secondary stays inactive until its wanted level outlasts the dead band
    a_cmp_short: assert property ( // R3
        @(posedge core_clk) disable iff (rst)
        (!out[1] && run[1] < db_run) |=> !out[1])
        else $error("secondary active within short duty");

    // Primary falling edges pass in one cycle
    a_fall_fast: assert property ( // R4
        @(posedge core_clk) disable iff (rst)
        (out[0] && !tgt[0]) |=> !out[0] ##0 !pend[0])
        else $error("primary fall delayed");

    // Secondary rising edges with dead-band stay held back for four cycles
    a_rise_held: assert property ( // R4
        @(posedge core_clk) disable iff (rst)
        (!out[1] && !pend[1] && tgt[1] && db_osc != '0) |=> !out[1] [*4])
        else $error("secondary rise not delayed");

    // Zero dead-band follows the waveform with one cycle latency
    a_zero_follow: assert property ( // R8
        @(posedge core_clk) disable iff (rst)
        (db_osc == '0 && hb_en) |=> out == $past(tgt))
        else $error("zero dead-band outputs lag");

    // Zero dead-band switches both outputs together
    a_zero_both: assert property ( // R8
        @(posedge core_clk) disable iff (rst)
        (db_osc == '0 && hb_en && $past(hb_en) && $changed(out[0]))
        |-> $changed(out[1]))
        else $error("outputs switched apart");

    // Each access answered after exactly one wait cycle
    a_bus_answer: assert property (
        @(posedge core_clk) disable iff (rst)
        (req && waitreq) |=> !waitreq ##1 waitreq)
        else $error("bus answer timing wrong");

    // Primary drive enable drops the cycle after its direction bit is set
    a_dir_oe: assert property (
        @(posedge core_clk) disable iff (rst)
        cfg[HBP_CFG_DIR_PRI] |=> !primary_pwm_oe)
        else $error("primary driven while input");

endmodule : hbp_half_bridge

// ### hdl/hbp_pkg.sv
package hbp_pkg;

    // ****************************************
    // Dead-band field and timing
    // ****************************************
    // Width of the dead-band count field
    localparam int unsigned HBP_DB_W = 7;
    // Oscillator periods in one instruction cycle
    localparam int unsigned HBP_OSC_PER_ICYC = 4;

    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam int unsigned HBP_ADDR_W = 4;
    localparam logic [3:0] HBP_OFS_PWM_CTL = 4'h0;
    localparam logic [3:0] HBP_OFS_CFG = 4'h4;
    localparam logic [3:0] HBP_OFS_STATUS = 4'h8;

    // ****************************************
    // Configuration register fields
    // ****************************************
    localparam int unsigned HBP_CFG_W = 4;
    localparam int unsigned HBP_CFG_HB_EN = 0;
    localparam int unsigned HBP_CFG_DIR_PRI = 1;
    localparam int unsigned HBP_CFG_DIR_CMP = 2;
    localparam int unsigned HBP_CFG_C2_EN = 3;

    // ****************************************
    // Status register fields
    // ****************************************
    localparam int unsigned HBP_STS_PRI = 0;
    localparam int unsigned HBP_STS_CMP = 1;
    localparam int unsigned HBP_STS_CONFLICT = 2;
    localparam int unsigned HBP_STS_PEND_PRI = 3;
    localparam int unsigned HBP_STS_PEND_CMP = 4;

    // ****************************************
    // Values after reset
    // ****************************************
    localparam logic [6:0] HBP_PWM_CTL_RST = 7'h00;
    localparam logic [3:0] HBP_CFG_RST = 4'h6;
    localparam logic [31:0] HBP_RDATA_RST = 32'h0000_0000;

endpackage : hbp_pkg

// ### verification/hbp_switch_model.sv
`timescale 1ns/1ns
module hbp_switch_model (
    input wire logic high_gate, // Upper switch gate
    input wire logic high_en, // Upper gate pin driven
    input wire logic low_gate, // Lower switch gate
    input wire logic low_en, // Lower gate pin driven
    output logic shoot // Both switches conduct
);
    // ****
    // Conduction
    // ****
    // An undriven gate is pulled off by its gate resistor
    assign shoot = high_gate & high_en & low_gate & low_en;
endmodule : hbp_switch_model

// ### verification/tb_half_bridge_deadband_pwm.sv
`timescale 1ns/1ns
module tb_half_bridge_deadband_pwm;
    import hbp_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic pwm_in = 1'b0;
    logic [HBP_ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_writedata = '0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, pri, pri_oe, cmp, cmp_oe, shoot;
    int n_fail = 0;
    int num_checks = 0;
    int db = 0;
    bit hb = 1'b0;
    int cnt[2] = '{-1, -1};
    bit exp_o[2] = '{1'b0, 1'b0};
    logic [31:0] q;
    int dlist[4] = '{0, 1, 5, 127};

    // ****
    // Clock, design and far side
    // ****
    always #4 core_clk = ~core_clk;
    hbp_half_bridge DUT (.core_clk(core_clk), .rst(rst), .pwm_in(pwm_in),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .primary_pwm_out(pri), .primary_pwm_oe(pri_oe),
        .complement_pwm_out(cmp), .complement_pwm_oe(cmp_oe));
    hbp_switch_model SW (.high_gate(pri), .high_en(pri_oe), .low_gate(cmp),
        .low_en(cmp_oe), .shoot(shoot));

    // ****
    // Reference model of both outputs
    // ****
    // Only a rising wanted level waits out the dead band
    always @(posedge core_clk) begin
        bit want[2];
        want[0] = pwm_in;
        want[1] = hb & ~pwm_in;
        for (int i = 0; i < 2; i++) begin
            if (rst || !want[i]) begin
                exp_o[i] = 1'b0;
                cnt[i] = -1;
            end else if (!exp_o[i]) begin
                if (cnt[i] < 0) cnt[i] = HBP_OSC_PER_ICYC * db;
                else cnt[i] = cnt[i] - 1;
                if (cnt[i] == 0) exp_o[i] = 1'b1;
            end
        end
    end

    // Outputs compared every cycle once settled
    always @(negedge core_clk) begin
        if (!rst) begin
            check(32'(pri), 32'(exp_o[0]));
            check(32'(cmp), 32'(exp_o[1]));
            check(32'(shoot), 32'h0);
        end
    end

    // ****
    // Tasks
    // ****
    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        num_checks++;
        if (seen !== expv) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask : check

    task automatic report_and_stop;
        $display("checks=%0d fails=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    // One Avalon access, held until waitrequest is sampled low
    task automatic bus(input bit wr, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] rd);
        int k;
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        avs_byteenable <= be;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 20);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        // Let an edge pass so a following access never reassigns in this step
        @(posedge core_clk);
        if (k >= 20) begin
            n_fail++;
            report_and_stop();
        end
    endtask : bus

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] expv);
        bus(1'b0, a, 32'h0, 4'hF, q);
        check(q, expv);
    endtask : rd_chk

    // Random pulse widths, some shorter than the dead band
    task automatic pulses(input int n);
        repeat (n) begin
            pwm_in <= ~pwm_in;
            repeat ($urandom_range(4 * db + 6, 1)) @(posedge core_clk);
        end
    endtask : pulses

    // ****
    // Main sequence
    // ****
    initial begin
        void'($urandom(23));
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        rd_chk(HBP_OFS_PWM_CTL, 32'(HBP_PWM_CTL_RST));
        rd_chk(HBP_OFS_CFG, 32'(HBP_CFG_RST));
        rd_chk(4'hC, 32'h0);
        check(32'({pri_oe, cmp_oe}), 32'h0);
        pulses(20);
        $display("test reset_and_bridge_off done");
        pwm_in <= 1'b1;
        repeat (8) @(posedge core_clk);
        bus(1'b1, HBP_OFS_PWM_CTL, 32'h5, 4'h0, q);
        rd_chk(HBP_OFS_PWM_CTL, 32'h0);
        bus(1'b1, HBP_OFS_CFG, 32'h1, 4'h1, q);
        hb = 1'b1;
        repeat (2) @(posedge core_clk);
        check(32'({pri_oe, cmp_oe}), 32'h3);
        rd_chk(HBP_OFS_CFG, 32'h1);
        $display("test config done");
        foreach (dlist[i]) begin
            pwm_in <= 1'b1;
            repeat (4 * db + 8) @(posedge core_clk);
            bus(1'b1, HBP_OFS_PWM_CTL, 32'(dlist[i]), 4'h1, q);
            db = dlist[i];
            rd_chk(HBP_OFS_PWM_CTL, 32'(dlist[i]));
            pulses(14);
            $display("test deadband %0d done", db);
        end
        pwm_in <= 1'b1;
        repeat (4 * db + 8) @(posedge core_clk);
        bus(1'b1, HBP_OFS_CFG, 32'h9, 4'h1, q);
        rd_chk(HBP_OFS_STATUS, 32'h5);
        $display("test status done");
        report_and_stop();
    end
endmodule : tb_half_bridge_deadband_pwm
